// >>> src/pbe_pkg.sv
package pbe_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam logic [7:0] PBE_OFS_CTRL   = 8'h00;
    localparam logic [7:0] PBE_OFS_DECIM  = 8'h04;
    localparam logic [7:0] PBE_OFS_STATUS = 8'h08;
    localparam logic [7:0] PBE_OFS_ROI    = 8'h10;
    localparam int         PBE_ROI_STRIDE = 8;
    localparam int         PBE_ROI_NUM    = 4;
    localparam int         PBE_ROI_CUR    = 0;
    localparam int         PBE_ROI_MAX    = 1;
    localparam int         PBE_ROI_AUTO   = 2;
    localparam int         PBE_ROI_WB     = 3;

    // ****************************************
    // field positions and reset values
    // ****************************************
    localparam int         PBE_CTRL_BH_LSB  = 0;
    localparam int         PBE_CTRL_BV_LSB  = 4;
    localparam int         PBE_CTRL_MODE    = 8;
    localparam int         PBE_CTRL_COLOUR  = 9;
    localparam int         PBE_CTRL_DEPTH   = 12;
    localparam int         PBE_DECIM_H_LSB  = 0;
    localparam int         PBE_DECIM_V_LSB  = 4;
    localparam int         PBE_STAT_FCNT    = 16;
    localparam logic [2:0] PBE_FACTOR_RST   = 3'h1;
    localparam logic [1:0] PBE_DEPTH_RST    = 2'h0;
    localparam logic [15:0] PBE_MAX_8       = 16'h00FF;
    localparam logic [15:0] PBE_MAX_10      = 16'h03FF;
    localparam logic [15:0] PBE_MAX_12      = 16'h0FFF;

    typedef enum logic {PBE_SUM, PBE_AVG} pbe_mode_e;

    function automatic logic [1:0] pbe_log2(input logic [2:0] f);
        return (f == 3'h4) ? 2'h2 : ((f == 3'h2) ? 2'h1 : 2'h0);
    endfunction

    function automatic logic pbe_bin_ok(input logic [2:0] f);
        return (f == 3'h1) || (f == 3'h2) || (f == 3'h4);
    endfunction

endpackage

// >>> src/pbe_col_merge.sv
`timescale 1ns/1ps
module pbe_col_merge import pbe_pkg::*; #(
    parameter int PW = 12,
    parameter int AW = PW + 4,
    parameter int XW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          i_valid,
    input  wire logic [PW-1:0] i_data,
    input  wire logic          i_sol,
    input  wire logic          i_sof,
    input  wire logic          colour,
    input  wire logic [1:0]    lfc,
    output logic               o_valid,
    output logic [AW-1:0]      o_sum,
    output logic [XW-1:0]      o_col,
    output logic               o_sof
);

    // ****************************************
    // position within the line
    // ****************************************
    logic [XW-1:0] x_reg;
    logic [AW-1:0] acc_reg [2];
    logic          sof_pend_reg;

    wire [XW-1:0] x     = i_sol ? '0 : x_reg;
    wire          lane  = colour & x[0];
    wire [XW-1:0] k     = colour ? (x >> 1) : x;
    wire [XW-1:0] msk   = XW'((4'h1 << lfc) - 4'h1);
    wire          first = (k & msk) == '0;
    wire          last  = (k & msk) == msk;
    wire [XW-1:0] grp   = k >> lfc;
    wire [AW-1:0] sum   = (first ? '0 : acc_reg[lane]) + AW'(i_data);
    wire          emit  = i_valid & last;
    wire [XW-1:0] col   = colour ? {grp[XW-2:0], lane} : grp;

    // ****************************************
    // accumulate same-colour neighbours
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            x_reg        <= '0;
            acc_reg[0]   <= '0;
            acc_reg[1]   <= '0;
            sof_pend_reg <= 1'b0;
            o_valid      <= 1'b0;
            o_sum        <= '0;
            o_col        <= '0;
            o_sof        <= 1'b0;
        end else begin
            o_valid <= emit;
            o_sof   <= emit & (i_sof | sof_pend_reg);
            sof_pend_reg <= (i_valid & i_sof & ~emit) | (sof_pend_reg & ~emit);
            if (i_valid) begin
                x_reg         <= x + 1'b1;
                acc_reg[lane] <= sum;
            end
            if (emit) begin
                o_sum <= sum;
                o_col <= col;
            end
        end
    end

endmodule

// >>> src/pbe_row_merge.sv
`timescale 1ns/1ps
module pbe_row_merge import pbe_pkg::*; #(
    parameter int PW   = 12,
    parameter int AW   = PW + 4,
    parameter int XW   = 8,
    parameter int MAXW = 256
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          c_valid,
    input  wire logic [AW-1:0] c_sum,
    input  wire logic [XW-1:0] c_col,
    input  wire logic          c_sof,
    input  wire logic          colour,
    input  wire logic [1:0]    lfr,
    input  wire logic [1:0]    lfc,
    input  wire pbe_mode_e     mode,
    input  wire logic [1:0]    depth,
    output logic               out_valid,
    output logic [PW-1:0]      out_data,
    output logic               out_sol,
    output logic               out_sof
);

    // ****************************************
    // row tracking
    // ****************************************
    logic [15:0]   y_reg;
    logic          sof_pend_reg;
    logic [AW-1:0] mem [2*MAXW];

    wire          lstart = c_valid & (c_col == '0);
    wire [15:0]   y      = c_sof ? 16'h0 : (lstart ? y_reg + 16'h1 : y_reg);
    wire          lane   = colour & y[0];
    wire [15:0]   k      = colour ? (y >> 1) : y;
    wire [15:0]   msk    = 16'((4'h1 << lfr) - 4'h1);
    wire          first  = (k & msk) == 16'h0;
    wire          last   = (k & msk) == msk;
    wire [XW:0]   idx    = {lane, c_col};
    wire [AW-1:0] tot    = (first ? '0 : mem[idx]) + c_sum;
    wire          emit   = c_valid & last;

    // ****************************************
    // sum clamp or average shift
    // ****************************************
    wire [15:0]   maxv16 = (depth == 2'h2) ? PBE_MAX_12 :
                           ((depth == 2'h1) ? PBE_MAX_10 : PBE_MAX_8);
    wire [AW-1:0] maxv   = AW'(maxv16);
    wire [AW-1:0] avg    = tot >> (3'(lfr) + 3'(lfc));
    wire [AW-1:0] clmp   = (tot > maxv) ? maxv : tot;
    wire [AW-1:0] res    = (mode == PBE_AVG) ? avg : clmp;

    always_ff @(posedge pclk) begin
        if (c_valid & ~last) begin
            mem[idx] <= tot;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            y_reg        <= 16'h0;
            sof_pend_reg <= 1'b0;
            out_valid    <= 1'b0;
            out_data     <= '0;
            out_sol      <= 1'b0;
            out_sof      <= 1'b0;
        end else begin
            if (c_valid) begin
                y_reg <= y;
            end
            sof_pend_reg <= (c_valid & c_sof & ~emit) | (sof_pend_reg & ~emit);
            out_valid    <= emit;
            out_sol      <= emit & (c_col == '0);
            out_sof      <= emit & (c_sof | sof_pend_reg);
            if (emit) begin
                out_data <= res[PW-1:0];
            end
        end
    end

endmodule

// >>> src/pbe_top.sv
`timescale 1ns/1ps
// Function
// - colour sensors merge same-colour neighbours only
// - 2x2 colour merges four sub-pixels into one
// - mono sensors merge directly adjacent pixels
// - independent horizontal and vertical factors
// - factor one passes pixels through, clamped to the depth maximum in sum mode
// - factors two, four set merged count
// - horizontal merges rows, vertical merges columns
// - sum or average, at every factor including one
// - sum mode adds all merged pixels
// - average mode outputs the mean
// - four ROIs rescale when binning enabled
// - ROI value divided by matching factor
// - binning and decimation exclusive per direction
module pbe_top import pbe_pkg::*; #(
    parameter int PW     = 12,
    parameter int MAXW   = 256,
    parameter int SENS_W = 1200,
    parameter int SENS_H = 960
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic [7:0]    paddr,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [31:0]   pwdata,
    input  wire logic [3:0]    pstrb,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          in_valid,
    input  wire logic [PW-1:0] in_data,
    input  wire logic          in_sol,
    input  wire logic          in_sof,
    output logic               out_valid,
    output logic [PW-1:0]      out_data,
    output logic               out_sol,
    output logic               out_sof,
    output logic [2:0]         decim_h_factor,
    output logic [2:0]         decim_v_factor
);

    localparam int AW = PW + 4;
    localparam int XW = $clog2(MAXW);
    localparam logic [31:0] ROI_SIZE_RST = {16'(SENS_H), 16'(SENS_W)};

    // ****************************************
    // configuration registers
    // ****************************************
    logic [2:0]  bin_h_reg;
    logic [2:0]  bin_v_reg;
    logic [2:0]  dec_h_reg;
    logic [2:0]  dec_v_reg;
    pbe_mode_e   mode_reg;
    logic        colour_reg;
    logic [1:0]  depth_reg;
    logic [31:0] roi_ofs_reg  [PBE_ROI_NUM];
    logic [31:0] roi_size_reg [PBE_ROI_NUM];
    logic [31:0] prdata_reg;

    // ****************************************
    // configuration in use for current frame
    // ****************************************
    logic [1:0]  act_lh_reg;
    logic [1:0]  act_lv_reg;
    pbe_mode_e   act_mode_reg;
    logic        act_colour_reg;
    logic [1:0]  act_depth_reg;
    logic [15:0] frame_cnt_reg;

    // ****************************************
    // bus decode
    // ****************************************
    wire        wr_en     = psel & penable & pwrite;
    wire        rd_setup  = psel & ~penable & ~pwrite;
    wire        hit_ctrl  = paddr == PBE_OFS_CTRL;
    wire        hit_decim = paddr == PBE_OFS_DECIM;
    wire        hit_stat  = paddr == PBE_OFS_STATUS;
    wire [31:0] wmask     = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [1:0]  cfg_lh    = pbe_log2(bin_h_reg);
    wire [1:0]  cfg_lv    = pbe_log2(bin_v_reg);

    logic [PBE_ROI_NUM-1:0] hit_ofs;
    logic [PBE_ROI_NUM-1:0] hit_size;
    logic [31:0]            ofs_rd  [PBE_ROI_NUM];
    logic [31:0]            size_rd [PBE_ROI_NUM];

    wire mapped = hit_ctrl | hit_decim | hit_stat | (|hit_ofs) | (|hit_size);

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_reg;

    // ****************************************
    // control and decimation words
    // ****************************************
    wire [31:0] ctrl_rd = (32'(bin_h_reg) << PBE_CTRL_BH_LSB)
                        | (32'(bin_v_reg) << PBE_CTRL_BV_LSB)
                        | (32'(mode_reg) << PBE_CTRL_MODE)
                        | (32'(colour_reg) << PBE_CTRL_COLOUR)
                        | (32'(depth_reg) << PBE_CTRL_DEPTH);
    wire [31:0] decim_rd = (32'(dec_h_reg) << PBE_DECIM_H_LSB)
                         | (32'(dec_v_reg) << PBE_DECIM_V_LSB);
    wire [31:0] stat_rd  = (32'(frame_cnt_reg) << PBE_STAT_FCNT)
                         | (32'(act_lh_reg) << 0) | (32'(act_lv_reg) << 2)
                         | (32'(act_mode_reg) << 4) | (32'(act_colour_reg) << 5)
                         | (32'(act_depth_reg) << 6);

    wire [31:0] ctrl_new  = (ctrl_rd & ~wmask) | (pwdata & wmask);
    wire [31:0] decim_new = (decim_rd & ~wmask) | (pwdata & wmask);
    wire [2:0]  n_bh      = ctrl_new[PBE_CTRL_BH_LSB +: 3];
    wire [2:0]  n_bv      = ctrl_new[PBE_CTRL_BV_LSB +: 3];
    wire [1:0]  n_depth   = ctrl_new[PBE_CTRL_DEPTH +: 2];
    wire [2:0]  n_dh      = decim_new[PBE_DECIM_H_LSB +: 3];
    wire [2:0]  n_dv      = decim_new[PBE_DECIM_V_LSB +: 3];

    // refused values leave the field unchanged
    wire bh_ok = pbe_bin_ok(n_bh) & ((n_bh == 3'h1) | (dec_h_reg == 3'h1));
    wire bv_ok = pbe_bin_ok(n_bv) & ((n_bv == 3'h1) | (dec_v_reg == 3'h1));
    wire dh_ok = ((n_dh == 3'h1) | (n_dh == 3'h2)) & ((n_dh == 3'h1) | (bin_h_reg == 3'h1));
    wire dv_ok = ((n_dv == 3'h1) | (n_dv == 3'h2)) & ((n_dv == 3'h1) | (bin_v_reg == 3'h1));
    wire dp_ok = n_depth != 2'h3;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bin_h_reg  <= PBE_FACTOR_RST;
            bin_v_reg  <= PBE_FACTOR_RST;
            dec_h_reg  <= PBE_FACTOR_RST;
            dec_v_reg  <= PBE_FACTOR_RST;
            mode_reg   <= PBE_SUM;
            colour_reg <= 1'b0;
            depth_reg  <= PBE_DEPTH_RST;
        end else if (wr_en & hit_ctrl) begin
            if (bh_ok) begin
                bin_h_reg <= n_bh;
            end
            if (bv_ok) begin
                bin_v_reg <= n_bv;
            end
            if (dp_ok) begin
                depth_reg <= n_depth;
            end
            mode_reg   <= pbe_mode_e'(ctrl_new[PBE_CTRL_MODE]);
            colour_reg <= ctrl_new[PBE_CTRL_COLOUR];
        end else if (wr_en & hit_decim) begin
            if (dh_ok) begin
                dec_h_reg <= n_dh;
            end
            if (dv_ok) begin
                dec_v_reg <= n_dv;
            end
        end
    end

    assign decim_h_factor = dec_h_reg;
    assign decim_v_factor = dec_v_reg;

    // ****************************************
    // ROI registers with rescaled readback
    // ****************************************
    for (genvar i = 0; i < PBE_ROI_NUM; i++) begin : g_roi
        localparam logic [7:0] A_OFS  = 8'(int'(PBE_OFS_ROI) + PBE_ROI_STRIDE * i);
        localparam logic [7:0] A_SIZE = 8'(int'(PBE_OFS_ROI) + PBE_ROI_STRIDE * i + 4);
        localparam bit         WR_OK  = (i != PBE_ROI_MAX);

        assign hit_ofs[i]  = paddr == A_OFS;
        assign hit_size[i] = paddr == A_SIZE;
        assign ofs_rd[i]   = {roi_ofs_reg[i][31:16] >> cfg_lv,
                              roi_ofs_reg[i][15:0] >> cfg_lh};
        assign size_rd[i]  = {roi_size_reg[i][31:16] >> cfg_lv,
                              roi_size_reg[i][15:0] >> cfg_lh};

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                roi_ofs_reg[i]  <= 32'h0000_0000;
                roi_size_reg[i] <= ROI_SIZE_RST;
            end else if (wr_en & WR_OK & hit_ofs[i]) begin
                roi_ofs_reg[i] <= (roi_ofs_reg[i] & ~wmask) | (pwdata & wmask);
            end else if (wr_en & WR_OK & hit_size[i]) begin
                roi_size_reg[i] <= (roi_size_reg[i] & ~wmask) | (pwdata & wmask);
            end
        end
    end

    // ****************************************
    // read data, captured in setup phase
    // ****************************************
    logic [31:0] rdata;

    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_ctrl) begin
            rdata = ctrl_rd;
        end else if (hit_decim) begin
            rdata = decim_rd;
        end else if (hit_stat) begin
            rdata = stat_rd;
        end
        for (int j = 0; j < PBE_ROI_NUM; j++) begin
            if (hit_ofs[j]) begin
                rdata = ofs_rd[j];
            end
            if (hit_size[j]) begin
                rdata = size_rd[j];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (rd_setup) begin
            prdata_reg <= rdata;
        end
    end

    // ****************************************
    // frame-boundary configuration update
    // ****************************************
    wire       sof_now = in_valid & in_sof;
    wire [1:0] eff_lh  = sof_now ? cfg_lh : act_lh_reg;
    wire [1:0] eff_lv  = sof_now ? cfg_lv : act_lv_reg;
    wire       eff_col = sof_now ? colour_reg : act_colour_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            act_lh_reg     <= 2'h0;
            act_lv_reg     <= 2'h0;
            act_mode_reg   <= PBE_SUM;
            act_colour_reg <= 1'b0;
            act_depth_reg  <= PBE_DEPTH_RST;
            frame_cnt_reg  <= 16'h0000;
        end else if (sof_now) begin
            act_lh_reg     <= cfg_lh;
            act_lv_reg     <= cfg_lv;
            act_mode_reg   <= mode_reg;
            act_colour_reg <= colour_reg;
            act_depth_reg  <= depth_reg;
            frame_cnt_reg  <= frame_cnt_reg + 16'h0001;
        end
    end

    // ****************************************
    // pixel datapath
    // ****************************************
    logic          c_valid;
    logic [AW-1:0] c_sum;
    logic [XW-1:0] c_col;
    logic          c_sof;

    // vertical factor merges along the line
    pbe_col_merge #(.PW(PW), .AW(AW), .XW(XW)) u_col (
        .pclk    (pclk),
        .presetn (presetn),
        .i_valid (in_valid),
        .i_data  (in_data),
        .i_sol   (in_sol),
        .i_sof   (in_sof),
        .colour  (eff_col),
        .lfc     (eff_lv),
        .o_valid (c_valid),
        .o_sum   (c_sum),
        .o_col   (c_col),
        .o_sof   (c_sof)
    );

    // horizontal factor merges across rows
    pbe_row_merge #(.PW(PW), .AW(AW), .XW(XW), .MAXW(MAXW)) u_row (
        .pclk      (pclk),
        .presetn   (presetn),
        .c_valid   (c_valid),
        .c_sum     (c_sum),
        .c_col     (c_col),
        .c_sof     (c_sof),
        .colour    (act_colour_reg),
        .lfr       (act_lh_reg),
        .lfc       (act_lv_reg),
        .mode      (act_mode_reg),
        .depth     (act_depth_reg),
        .out_valid (out_valid),
        .out_data  (out_data),
        .out_sol   (out_sol),
        .out_sof   (out_sof)
    );

    wire unused_ok = &{1'b0, eff_lh};

endmodule

// >>> tb/pbe_top_properties.sv
`timescale 1ns/1ps
module pbe_top_props import pbe_pkg::*; #(
    parameter int PW     = 12,
    parameter int SENS_W = 1200,
    parameter int SENS_H = 960
) (
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic [7:0]    paddr,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [31:0]   pwdata,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          in_valid,
    input wire logic [PW-1:0] in_data,
    input wire logic          in_sol,
    input wire logic          in_sof,
    input wire logic          out_valid,
    input wire logic [PW-1:0] out_data,
    input wire logic          out_sol,
    input wire logic          out_sof,
    input wire logic [2:0]    decim_h_factor,
    input wire logic [2:0]    decim_v_factor
);
    // ****************************************
    // configuration mirror
    // ****************************************
    logic [31:0]   ctrl_q;
    logic [31:0]   act_q;
    wire  [31:0]   cur_w   = in_sof ? ctrl_q : act_q;
    wire           unity_w = (cur_w[2:0] == 3'h1) && (cur_w[6:4] == 3'h1);
    wire  [PW-1:0] lim_w   = (act_q[13:12] == 2'h0) ? PW'(12'h0FF) :
                             ((act_q[13:12] == 2'h1) ? PW'(12'h3FF) : PW'(12'hFFF));
    wire           unm_w   = !(paddr inside {8'h00, 8'h04, 8'h08} ||
                               (paddr >= 8'h10 && paddr <= 8'h2C));
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 32'h0000_0011;
            act_q  <= 32'h0000_0011;
        end else begin
            if (psel && penable && pwrite && paddr == 8'h00) ctrl_q <= pwdata;
            if (in_valid && in_sof) act_q <= ctrl_q;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_unity_echo: assert property (in_valid && unity_w |-> ##2 out_valid &&
        out_data == $past(in_data, 2)) else $error("unity pixel changed");
    a_unity_flags: assert property (in_valid && unity_w |-> ##2
        out_sof == $past(in_sof, 2) && out_sol == $past(in_sol, 2)) else $error("flag lost");
    a_depth_limit: assert property (out_valid |-> out_data <= lim_w)
        else $error("pixel above depth maximum");
    a_sof_line: assert property (out_sof |-> out_sol && out_valid)
        else $error("frame start without line start");
    a_out_cause: assert property (out_valid |-> $past(in_valid, 2))
        else $error("output without group end");
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'h0 |->
        pready && pslverr == unm_w) else $error("decode error wrong");
    a_max_roi: assert property (psel && penable && !pwrite && paddr == 8'h1C |->
        prdata == {16'(SENS_H >> ctrl_q[6:5]), 16'(SENS_W >> ctrl_q[2:1])})
        else $error("max size not scaled");
    a_decim_excl: assert property ((decim_h_factor == 3'h1 || ctrl_q[2:0] == 3'h1) &&
        (decim_v_factor == 3'h1 || ctrl_q[6:4] == 3'h1)) else $error("decim with binning");
    a_decim_legal: assert property (decim_h_factor inside {3'h1, 3'h2} &&
        decim_v_factor inside {3'h1, 3'h2}) else $error("bad decimation factor");
    c_clamp: cover property (out_valid && out_data == lim_w);
    c_err: cover property (pslverr);
    c_bin: cover property (in_valid && in_sof && !unity_w);
endmodule
bind pbe_top pbe_top_props #(.PW(PW), .SENS_W(SENS_W), .SENS_H(SENS_H)) chk_u (.pclk,
    .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .in_valid, .in_data, .in_sol, .in_sof, .out_valid, .out_data, .out_sol, .out_sof,
    .decim_h_factor, .decim_v_factor);

// >>> tb/pbe_sensor_model.sv
`timescale 1ns/1ps
module pbe_sensor_model #(
    parameter int W = 8,
    parameter int H = 8
) (
    input  wire logic       pclk,
    input  wire logic       start,
    input  wire logic [3:0] gap,
    output logic            valid,
    output logic [11:0]     data,
    output logic            sol,
    output logic            sof,
    output logic            done
);
    // ****************************************
    // readout of one frame per start
    // ****************************************
    initial begin
        {valid, data, sol, sof, done} = 16'h0001;
        forever begin
            @(posedge pclk);
            if (start === 1'b1) begin
                done <= 1'b0;
                for (int r = 0; r < H; r++) begin
                    for (int c = 0; c < W; c++) begin
                        valid <= 1'b1;
                        data  <= 12'(r * 16 + c * 3 + 5);
                        sol   <= (c == 0);
                        sof   <= (r == 0 && c == 0);
                        @(posedge pclk);
                        for (int g = 0; g < gap; g++) begin
                            {valid, sol, sof} <= 3'h0;
                            data <= ~data;
                            @(posedge pclk);
                        end
                    end
                end
                {valid, sol, sof} <= 3'h0;
                data <= ~data;
                done <= 1'b1;
            end
        end
    end
endmodule

// >>> tb/pixel_binning_engine_tb_top.sv
`timescale 1ns/1ps
module pixel_binning_engine_tb_top import pbe_pkg::*;;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb, gap;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic        in_valid, in_sol, in_sof, start, done, out_valid, out_sol, out_sof;
    logic [11:0] in_data, out_data;
    logic [2:0]  decim_h_factor, decim_v_factor;
    logic [13:0] q_out[$];
    int          errors, num_checks, cyc;
    // factors h, v, mode, colour, depth, gap
    logic [23:0] cfg_t[8] = '{24'h110000, 24'h111001, 24'h121020, 24'h210022,
                              24'h440000, 24'h421010, 24'h221120, 24'h240120};
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    pbe_top dut_u (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .in_valid, .in_data, .in_sol, .in_sof, .out_valid,
        .out_data, .out_sol, .out_sof, .decim_h_factor, .decim_v_factor);
    pbe_sensor_model snr_u (.pclk, .start, .gap, .valid(in_valid), .data(in_data),
        .sol(in_sol), .sof(in_sof), .done);
    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic complete_run();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk_word(input string n, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_pix(input string n, input logic [11:0] e, input logic [11:0] g);
        chk_word(n, 32'(e), 32'(g));
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata, pstrb} <= {1'b1, 1'b0, w, a, d, s};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    function automatic logic [11:0] expv(input int orow, oc, fh, fv, m, c, d);
        int s, r, k, mx;
        s = 0;
        mx = (d == 0) ? 255 : ((d == 1) ? 1023 : 4095);
        for (int i = 0; i < fh; i++) begin
            for (int j = 0; j < fv; j++) begin
                r = c ? (orow / 2) * 2 * fh + orow % 2 + 2 * i : orow * fh + i;
                k = c ? (oc / 2) * 2 * fv + oc % 2 + 2 * j : oc * fv + j;
                s += r * 16 + k * 3 + 5;
            end
        end
        if (m == 1) s = s / (fh * fv);
        else if (s > mx) s = mx;
        return 12'(s);
    endfunction
    task automatic frame(input logic [23:0] t);
        int fh, fv, nc, no;
        fh = t[23:20];
        fv = t[19:16];
        apb(1'b1, PBE_OFS_CTRL, {18'h0, t[5:4], 2'h0, t[8], t[12], 1'b0, t[18:16], 1'b0,
            t[22:20]});
        q_out.delete();
        @(posedge pclk);
        {gap, start} <= {t[3:0], 1'b1};
        @(posedge pclk);
        start <= 1'b0;
        do @(posedge pclk);
        while (done !== 1'b1);
        repeat (4) @(posedge pclk);
        nc = 8 / fv;
        no = (8 / fh) * nc;
        chk_word("count", 32'(no), 32'(q_out.size()));
        for (int k = 0; k < no && k < q_out.size(); k++) begin
            chk_pix("pixel", expv(k / nc, k % nc, fh, fv, t[12], t[8], t[5:4]),
                q_out[k][11:0]);
            chk_pix("flags", {10'h0, k == 0, k % nc == 0}, {10'h0, q_out[k][13:12]});
        end
    endtask
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (out_valid === 1'b1) q_out.push_back({out_sof, out_sol, out_data});
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, start, gap} = 0;
        {errors, num_checks, cyc} = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, PBE_OFS_CTRL, 32'h0);
        chk_word("ctrl", 32'h0000_0011, rd);
        apb(1'b0, PBE_OFS_DECIM, 32'h0);
        chk_word("decim", 32'h0000_0011, rd);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(8'h14 + 8 * i), 32'h0);
            chk_word("roi size", 32'h03C0_04B0, rd);
        end
        apb(1'b0, 8'h0C, 32'h0);
        chk_word("unmapped", 32'h0000_0001, {31'h0, err});
        for (int i = 0; i < 8; i++) frame(cfg_t[i]);
        apb(1'b0, PBE_OFS_STATUS, 32'h0);
        chk_word("status", 32'h0008_00A9, rd);
        apb(1'b1, PBE_OFS_CTRL, 32'h0000_0024);
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(8'h14 + 8 * i), 32'h0);
            chk_word("roi size", 32'h01E0_012C, rd);
        end
        apb(1'b1, 8'h20, 32'hAA32_0064, 4'h7);
        apb(1'b0, 8'h20, 32'h0);
        chk_word("roi offset", 32'h0019_0019, rd);
        apb(1'b1, PBE_OFS_CTRL, 32'h0000_0021);
        apb(1'b1, PBE_OFS_DECIM, 32'h0000_0022);
        @(posedge pclk);
        chk_word("decim", 32'h0000_000A, {26'h0, decim_v_factor, decim_h_factor});
        apb(1'b1, PBE_OFS_DECIM, 32'h0000_0011);
        complete_run();
    end
endmodule
